/* fse_defines.vh */
// Shared constants for the FSK demodulator and reply encoder
`ifndef FSE_DEFINES_VH
`define FSE_DEFINES_VH
// ==========================================================
// Clock and timing
`define FSE_CLK_MHZ       40
`define FSE_T_DIAGWIN_US  100
`define FSE_CYC_DIAGWIN   (`FSE_T_DIAGWIN_US * `FSE_CLK_MHZ)
`define FSE_T_DWRITE_US   79
`define FSE_CYC_DWRITE    (`FSE_T_DWRITE_US * `FSE_CLK_MHZ)
`define FSE_T_RDDLY_US    100
`define FSE_CYC_RDDLY     (`FSE_T_RDDLY_US * `FSE_CLK_MHZ)
`define FSE_T_BAUD_US     64
`define FSE_CYC_BAUD      (`FSE_T_BAUD_US * `FSE_CLK_MHZ)
`define FSE_T_DIAG_US     2000
`define FSE_T_HOLD_US     1000
`define FSE_T_READ_US     20000
`define FSE_T_DSTOP_US    128
// ==========================================================
// Period window, divider, threshold offsets, bytes
`define FSE_PER_MIN       8'h70
`define FSE_PER_MAX       8'h7D
`define FSE_DIV_DEF       7'h77
`define FSE_DIV_BASE      7'h71
`define FSE_HYST_HI       8'h05
`define FSE_HYST_LO       8'h07
`define FSE_DIAG_GOOD     8'hAF
`define FSE_DIAG_BAD      8'hFF
`define FSE_START_PAT     12'h00F
`endif

/* fse_fifo.v */
// Byte FIFO between the demodulator and the reply encoder
module fse_fifo #(
	parameter W = 8,
	parameter D = 8,
	parameter AW = 3
) (
	input  wire          clk_sys,
	input  wire          nrst,
	input  wire          flush,
	input  wire [W-1:0]  in_data,
	input  wire          in_valid,
	output wire          in_ready,
	output reg  [W-1:0]  out_data,
	output wire          out_valid,
	input  wire          out_ready
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0]   cnt;
	wire wr = in_valid && in_ready;
	wire rd = out_valid && out_ready;
	assign in_ready  = (cnt != D[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	// ==========================================================
	// Pointers and count; flush drops everything held
	always @(posedge clk_sys) begin
		if (!nrst || flush) begin
			wp  <= {AW{1'b0}};
			rp  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (wr) wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
			if (rd) rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
			cnt <= cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
		end
	end
	// Storage has no reset, only the pointers and count do
	always @(posedge clk_sys) begin
		if (wr) mem[wp] <= in_data;
	end
	always @* begin
		out_data = mem[rp];
	end
endmodule

/* fse_top.v */
// FSK period demodulator, antenna diagnosis, carrier divider and reply encoder
`include "fse_defines.vh"
// Function
// - Diagnosis accepts eight consecutive counts 112..125 inside a 0.1 ms window
// - Diagnosis signal only counts during the charge phase
// - 2 ms into charge send 0xAF if good, 0xFF on no oscillation or short
// - Sync mode keeps drivers on up to 1 ms after diagnosis
// - Divider defaults to 119 of the 16 MHz clock
// - Divider selectable in single steps 114 to 124
// - Each limiter period measured by counting 16 MHz ticks
// - 12-bit comparison register, start on 8 below then 4 above
// - Two-period filter in front of the start register
// - Measure resonance threshold first, then hunt for the start bit
// - Filter bit stream and buffer it byte-wise before the encoder
// - Valid count 112..125, average of eight valid counts accepted
// - Write mode measurement starts at host line fall plus fixed delay
// - Read mode measurement start is delayed for a stable signal
// - Accepted average can load the divider for carrier adaptation
// - Threshold is average plus 5 or plus 7 for hysteresis
// - Async frames LSB first at 15.625 kbaud, high start, low stop
// - Transponder data bits are inverted on the reply output
// - Sending starts after the start bit; start byte goes first
// - Stop and idle on host line low or 20 ms into read
// - Sync mode raises output when a byte is ready, host clocks eight falls
module fse_top #(
	parameter       PPB       = 16,
	parameter [19:0] CYC_DIAG  = `FSE_T_DIAG_US * `FSE_CLK_MHZ,
	parameter [19:0] CYC_HOLD  = `FSE_T_HOLD_US * `FSE_CLK_MHZ,
	parameter [19:0] CYC_READ  = `FSE_T_READ_US * `FSE_CLK_MHZ,
	parameter [19:0] CYC_DSTOP = `FSE_T_DSTOP_US * `FSE_CLK_MHZ
) (
	input  wire       clk_sys,
	input  wire       nrst,
	input  wire       limiter_in,
	input  wire       diag_in,
	input  wire       short_fault,
	input  wire       charge_phase,
	input  wire       read_phase,
	input  wire       write_mode,
	input  wire       sync_mode,
	input  wire [3:0] div_sel,
	input  wire       host_control_line,
	output reg        serial_reply_output,
	output reg        carrier_out,
	output reg        drivers_hold,
	output reg  [6:0] div_factor,
	output reg  [7:0] reso_avg,
	output reg        reso_valid,
	output reg        start_found
);
	localparam [2:0] RX_IDLE = 3'd0, RX_WAIT = 3'd1, RX_MEAS = 3'd2, RX_HUNT = 3'd3, RX_DATA = 3'd4;
	localparam [1:0] TX_IDLE = 2'd0, TX_ASYNC = 2'd1, TX_SYNC = 2'd2;
	localparam [4:0] BIT_INIT = PPB - PPB / 2 - 4;
	// Reload values sized to their counters so no bits are dropped silently
	localparam [11:0] BAUD_LAST = `FSE_CYC_BAUD - 1;
	localparam [11:0] DLY_WRITE = `FSE_CYC_DWRITE;
	localparam [11:0] DLY_READ  = `FSE_CYC_RDDLY;

	function in_win;
		input [7:0] p;
		in_win = (p >= `FSE_PER_MIN) && (p <= `FSE_PER_MAX);
	endfunction

	// ==========================================================
	// 16 MHz tick from 40 MHz: add 2, wrap at 5
	reg [2:0] acc;
	wire      tick = (acc >= 3'd3);
	always @(posedge clk_sys) begin
		if (!nrst) acc <= 3'd0;
		else acc <= tick ? acc - 3'd3 : acc + 3'd2;
	end

	// ==========================================================
	// Carrier divider, selection and auto adaptation
	reg [6:0] next_div;
	reg [6:0] div_cnt;
	always @* begin
		next_div = `FSE_DIV_DEF;
		if (div_sel == 4'hF) begin
			if (reso_valid) next_div = reso_avg[6:0];
		end else if (div_sel != 4'h0 && div_sel <= 4'hB)
			next_div = `FSE_DIV_BASE + {3'b000, div_sel};
	end
	always @(posedge clk_sys) begin
		if (!nrst) begin
			div_factor  <= `FSE_DIV_DEF;
			div_cnt     <= 7'd0;
			carrier_out <= 1'b0;
		end else begin
			div_factor <= next_div;
			if (tick) begin
				div_cnt     <= (div_cnt >= div_factor - 7'd1) ? 7'd0 : div_cnt + 7'd1;
				carrier_out <= (div_cnt < {1'b0, div_factor[6:1]});
			end
		end
	end

	// ==========================================================
	// Period counter on limiter rising edges, saturating
	reg       lim_d;
	reg [7:0] per_cnt;
	reg [7:0] period;
	reg       per_ev;
	always @(posedge clk_sys) begin
		if (!nrst) begin
			lim_d   <= 1'b0;
			per_cnt <= 8'd0;
			period  <= 8'd0;
			per_ev  <= 1'b0;
		end else begin
			lim_d  <= limiter_in;
			per_ev <= limiter_in && !lim_d;
			// The edge cycle's tick opens the next period: no tick is lost and the
			// count does not depend on where the edge falls in the tick pattern
			if (limiter_in && !lim_d) begin
				period  <= per_cnt;
				per_cnt <= {7'd0, tick};
			end else if (tick && per_cnt != 8'hFF)
				per_cnt <= per_cnt + 8'd1;
		end
	end

	// ==========================================================
	// Charge phase: diagnosis window, diag byte, driver hold
	reg        chg_d;
	reg [19:0] chg_tmr;
	reg [3:0]  diag_run;
	reg        diag_ok;
	reg        short_seen;
	reg        diag_push;
	reg [15:0] hold_tmr;
	reg        hold_arm;
	wire       in_diagwin = charge_phase && (chg_tmr < `FSE_CYC_DIAGWIN);
	always @(posedge clk_sys) begin
		if (!nrst) begin
			chg_d <= 1'b0; chg_tmr <= 20'd0; diag_run <= 4'd0; diag_ok <= 1'b0;
			short_seen <= 1'b0; diag_push <= 1'b0; hold_tmr <= 16'd0; hold_arm <= 1'b0;
			drivers_hold <= 1'b0;
		end else begin
			chg_d     <= charge_phase;
			diag_push <= 1'b0;
			if (charge_phase && !chg_d) begin
				chg_tmr <= 20'd0; diag_run <= 4'd0; diag_ok <= 1'b0; short_seen <= 1'b0;
			end else if (charge_phase) begin
				// Timer saturates so an overlong charge never pushes a second byte
				if (chg_tmr != 20'hFFFFF) chg_tmr <= chg_tmr + 20'd1;
				if (short_fault) short_seen <= 1'b1;
				// Diagnosis only looked at in charge, inside the window
				if (in_diagwin && diag_in && per_ev && !diag_ok) begin
					if (in_win(period)) begin
						diag_run <= diag_run + 4'd1;
						if (diag_run == 4'd7) diag_ok <= 1'b1;
					end else
						diag_run <= 4'd0;
				end
				if (chg_tmr == CYC_DIAG - 20'd1) diag_push <= 1'b1;
				// Hold starts where the diagnosis window closes
				if (chg_tmr == `FSE_CYC_DIAGWIN && sync_mode) hold_arm <= 1'b1;
			end
			// Hold counts on its own so it outlives a host line change
			if (hold_arm) begin
				hold_arm <= 1'b0; hold_tmr <= CYC_HOLD[15:0]; drivers_hold <= 1'b1;
			end else if (hold_tmr != 16'd0) begin
				hold_tmr <= hold_tmr - 16'd1;
				if (hold_tmr == 16'd1) drivers_hold <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Receive sequencer: delay, resonance measure, hunt, data
	reg [2:0]  rx_st;
	reg        rd_d;
	reg        hcl_d;
	reg [11:0] dly;
	reg [3:0]  m_cnt;
	reg [10:0] m_sum;
	reg        m_bad;
	reg        cmp_prev;
	reg        filt;
	reg [11:0] sr12;
	reg [4:0]  per_in_bit;
	reg [2:0]  bit_idx;
	reg [7:0]  byte_sr;
	reg        pend;
	reg [7:0]  pend_byte;
	reg [19:0] rd_tmr;
	reg [19:0] low_tmr;
	wire       fifo_in_ready;
	wire       hcl_fall = hcl_d && !host_control_line;
	wire [7:0] thr = reso_avg + (filt ? `FSE_HYST_HI : `FSE_HYST_LO);
	wire       raw_hi = (period > thr);
	// Sum of all eight counts, cut only once by the divide: halving each part
	// on its own would lose up to one count of the average
	wire [10:0] m_tot = m_sum + {3'b000, period};
	// Sync mode cannot stop on a single fall: those falls are the bit clock
	wire       stop_rd = (rx_st != RX_IDLE) &&
		((sync_mode ? (low_tmr >= CYC_DSTOP) : hcl_fall) || rd_tmr >= CYC_READ - 20'd1);
	always @(posedge clk_sys) begin
		if (!nrst) begin
			rx_st <= RX_IDLE; rd_d <= 1'b0; hcl_d <= 1'b1; dly <= 12'd0; m_cnt <= 4'd0;
			m_sum <= 11'd0; m_bad <= 1'b0; cmp_prev <= 1'b0; filt <= 1'b0; sr12 <= 12'd0;
			per_in_bit <= 5'd0; bit_idx <= 3'd0; byte_sr <= 8'd0; pend <= 1'b0;
			pend_byte <= 8'd0; rd_tmr <= 20'd0; low_tmr <= 20'd0;
			reso_avg <= 8'd0; reso_valid <= 1'b0; start_found <= 1'b0;
		end else begin
			rd_d  <= read_phase;
			hcl_d <= host_control_line;
			low_tmr <= host_control_line ? 20'd0 : (low_tmr == 20'hFFFFF ? low_tmr : low_tmr + 20'd1);
			rd_tmr  <= (rx_st == RX_IDLE) ? 20'd0 : rd_tmr + 20'd1;
			// The diagnosis byte owns the write port when both want it; the data byte waits
			if (pend && fifo_in_ready && !diag_push) pend <= 1'b0;
			if (stop_rd) begin
				// A waiting byte would otherwise leak into the next read after the flush
				rx_st <= RX_IDLE; start_found <= 1'b0;
				pend <= 1'b0;
			end else case (rx_st)
				RX_IDLE: begin
					if (write_mode && hcl_fall) begin
						dly <= DLY_WRITE; rx_st <= RX_WAIT;
					end else if (read_phase && !rd_d) begin
						dly <= DLY_READ; rx_st <= RX_WAIT;
					end
					m_cnt <= 4'd0; m_sum <= 11'd0; m_bad <= 1'b0;
				end
				RX_WAIT: begin
					if (dly == 12'd0) rx_st <= RX_MEAS;
					else dly <= dly - 12'd1;
				end
				RX_MEAS: if (per_ev) begin
					m_sum <= m_tot;
					m_cnt <= m_cnt + 4'd1;
					if (!in_win(period)) m_bad <= 1'b1;
					if (m_cnt == 4'd7) begin
						m_cnt <= 4'd0; m_sum <= 11'd0; m_bad <= 1'b0;
						// A bad set simply restarts the eight-period run
						if (!m_bad && in_win(period)) begin
							reso_avg   <= m_tot[10:3];
							reso_valid <= 1'b1;
							sr12 <= 12'd0; filt <= 1'b0; cmp_prev <= 1'b0;
							rx_st <= RX_HUNT;
						end
					end
				end
				RX_HUNT: if (per_ev) begin
					cmp_prev <= raw_hi;
					if (raw_hi == cmp_prev) filt <= raw_hi;
					sr12 <= {sr12[10:0], (raw_hi == cmp_prev) ? raw_hi : filt};
					if ({sr12[10:0], (raw_hi == cmp_prev) ? raw_hi : filt} == `FSE_START_PAT) begin
						start_found <= 1'b1;
						byte_sr <= 8'h80; bit_idx <= 3'd1; per_in_bit <= BIT_INIT;
						rx_st <= RX_DATA;
					end
				end
				RX_DATA: if (per_ev) begin
					cmp_prev <= raw_hi;
					if (raw_hi == cmp_prev) filt <= raw_hi;
					if (per_in_bit == PPB[4:0] - 5'd1) begin
						per_in_bit <= 5'd0;
						byte_sr <= {filt, byte_sr[7:1]};
						bit_idx <= bit_idx + 3'd1;
						if (bit_idx == 3'd7) begin
							pend      <= 1'b1;
							pend_byte <= ~{filt, byte_sr[7:1]};
						end
					end else
						per_in_bit <= per_in_bit + 5'd1;
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Byte buffer; diag byte wins the write port, data waits in pend
	wire [7:0] fifo_out;
	wire       fifo_out_valid;
	reg        fifo_out_ready;
	wire       diag_sel = diag_push;
	fse_fifo #(.W(8), .D(8), .AW(3)) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.flush     (stop_rd),
		.in_data   (diag_sel ? (diag_ok && !short_seen ? `FSE_DIAG_GOOD : `FSE_DIAG_BAD) : pend_byte),
		.in_valid  (diag_sel || pend),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	// ==========================================================
	// Reply encoder: async NRZ frames or host-clocked sync bytes
	reg [1:0]  tx_st;
	reg [11:0] baud;
	reg [3:0]  tx_bit;
	reg [7:0]  tx_sr;
	always @* begin
		fifo_out_ready = (tx_st == TX_IDLE) && fifo_out_valid;
	end
	always @(posedge clk_sys) begin
		if (!nrst) begin
			tx_st <= TX_IDLE; baud <= 12'd0; tx_bit <= 4'd0; tx_sr <= 8'd0;
			serial_reply_output <= 1'b0;
		end else if (stop_rd) begin
			tx_st <= TX_IDLE; serial_reply_output <= 1'b0;
		end else case (tx_st)
			TX_IDLE: begin
				serial_reply_output <= 1'b0;
				if (fifo_out_valid) begin
					tx_sr <= fifo_out; tx_bit <= 4'd0; baud <= BAUD_LAST;
					serial_reply_output <= 1'b1;
					tx_st <= sync_mode ? TX_SYNC : TX_ASYNC;
				end
			end
			TX_ASYNC: begin
				if (baud != 12'd0) baud <= baud - 12'd1;
				else begin
					baud   <= BAUD_LAST;
					tx_bit <= tx_bit + 4'd1;
					if (tx_bit < 4'd8) begin
						serial_reply_output <= tx_sr[0];
						tx_sr <= {1'b0, tx_sr[7:1]};
					end else if (tx_bit == 4'd8)
						serial_reply_output <= 1'b0;
					else
						tx_st <= TX_IDLE;
				end
			end
			// Byte ends on the rise after the eighth fall, so the last bit stands its whole low phase
			TX_SYNC: begin
				if (hcl_fall && tx_bit < 4'd8) begin
					serial_reply_output <= tx_sr[0];
					tx_sr  <= {1'b0, tx_sr[7:1]};
					tx_bit <= tx_bit + 4'd1;
				end else if (tx_bit == 4'd8 && host_control_line && !hcl_d) begin
					serial_reply_output <= 1'b0;
					tx_st <= TX_IDLE;
				end
			end
			default: tx_st <= TX_IDLE;
		endcase
	end
endmodule

/* fse_top_asserts.sv */
// Port timing checker for fse_top
module fse_top_asserts #(
	parameter [19:0] CYC_HOLD = 20'h09C40
) (
	input wire       clk_sys,
	input wire       nrst,
	input wire       sync_mode,
	input wire [3:0] div_sel,
	input wire       host_control_line,
	input wire       serial_reply_output,
	input wire       drivers_hold,
	input wire [6:0] div_factor,
	input wire [7:0] reso_avg,
	input wire       reso_valid,
	input wire       start_found
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	reg [19:0] hold_cnt;
	// ==========================================================
	// Helper: length of the driver hold, so its bound needs no long repetition
	always @(posedge clk_sys) begin
		if (!nrst || !drivers_hold)
			hold_cnt <= 20'h00000;
		else
			hold_cnt <= hold_cnt + 20'h00001;
	end
	// ==========================================================
	// Divider, measurement, stop, hold length and async start bit relations
	a_div_step: assert property (div_sel >= 4'h1 && div_sel <= 4'hB |=>
		div_factor == 7'h71 + {3'h0, $past(div_sel)}) else $error("divider step wrong");
	a_div_dflt: assert property (div_sel == 4'h0 |=> div_factor == 7'h77)
		else $error("default divider wrong");
	a_auto_div: assert property (div_sel == 4'hF && reso_valid |=> div_factor == reso_avg[6:0])
		else $error("auto divider not loaded");
	a_reso_window: assert property ($rose(reso_valid) |-> reso_avg >= 8'h70 && reso_avg <= 8'h7D)
		else $error("average outside period window");
	a_reso_sticky: assert property (reso_valid |=> reso_valid)
		else $error("measurement valid dropped");
	a_start_order: assert property ($rose(start_found) |-> reso_valid)
		else $error("start bit before measurement");
	a_stop_host: assert property (!sync_mode && start_found && $fell(host_control_line)
		|-> ##[1:3] !start_found) else $error("no stop on host fall");
	a_hold_len: assert property ($fell(drivers_hold) |->
		hold_cnt <= CYC_HOLD && hold_cnt + 20'h00002 >= CYC_HOLD) else $error("hold length wrong");
	a_async_start: assert property (!sync_mode && $rose(serial_reply_output) |=>
		$stable(serial_reply_output) [*8]) else $error("start bit too short");
	c_reso: cover property ($rose(reso_valid));
	c_start: cover property ($rose(start_found));
	c_hold: cover property ($rose(drivers_hold));
endmodule
bind fse_top fse_top_asserts #(.CYC_HOLD(CYC_HOLD)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.sync_mode(sync_mode), .div_sel(div_sel), .host_control_line(host_control_line),
	.serial_reply_output(serial_reply_output), .drivers_hold(drivers_hold), .div_factor(div_factor),
	.reso_avg(reso_avg), .reso_valid(reso_valid), .start_found(start_found));

/* fse_host_model.sv */
// Host and transponder model on the control line, reply output and limiter
module fse_host_model (
	input  wire       clk_sys,
	input  wire       serial_reply_output,
	input  wire [9:0] lim_per,
	output reg        limiter_in = 1'b0,
	output reg        host_control_line = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [9:0] ph = 10'h000;
	integer   i;
	// Square wave of lim_per cycles; zero stops it low like a dead antenna
	always @(posedge clk_sys) begin
		ph <= (ph + 10'h001 >= lim_per) ? 10'h000 : ph + 10'h001;
		limiter_in <= #1 (ph < {1'b0, lim_per[9:1]});
	end
	// Waits for the ready level, then clocks eight falls of 4 us period
	task sync_read(output [7:0] b, output ok);
		begin
			ok = 1'b0;
			for (i = 0; i < 20000 && !ok; i = i + 1) begin
				@(posedge clk_sys);
				ok = serial_reply_output;
			end
			repeat (40) @(posedge clk_sys);
			for (i = 0; i < 8; i = i + 1) begin
				#1 host_control_line = 1'b0;
				repeat (80) @(posedge clk_sys);
				b[i] = serial_reply_output;
				#1 host_control_line = 1'b1;
				repeat (80) @(posedge clk_sys);
			end
		end
	endtask
	// Samples one frame mid-bit; ok means high start and low stop
	task async_read(output [7:0] b, output ok);
		begin
			ok = 1'b0;
			for (i = 0; i < 9000 && !ok; i = i + 1) begin
				@(posedge clk_sys);
				ok = serial_reply_output;
			end
			repeat (1280) @(posedge clk_sys);
			ok = serial_reply_output;
			for (i = 0; i < 8; i = i + 1) begin
				repeat (2560) @(posedge clk_sys);
				b[i] = serial_reply_output;
			end
			repeat (2560) @(posedge clk_sys);
			ok = ok & !serial_reply_output;
		end
	endtask
	// Low pulse of 130 us, long enough to stop yet short of a new cycle
	task end_read;
		begin
			#1 host_control_line = 1'b0;
			repeat (5200) @(posedge clk_sys);
			#1 host_control_line = 1'b1;
		end
	endtask
endmodule

/* fse_top_tb.sv */
// Self-checking bench of fse_top
module fse_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg        clk_sys = 1'b0;
	reg        nrst = 1'b0;
	reg        diag_in = 1'b0;
	reg        short_fault = 1'b0;
	reg        charge_phase = 1'b0;
	reg        read_phase = 1'b0;
	reg        write_mode = 1'b0;
	reg        sync_mode = 1'b0;
	reg  [3:0] div_sel = 4'h0;
	reg  [9:0] lim_per = 10'h000;
	wire       limiter_in;
	wire       host_control_line;
	wire       serial_reply_output;
	wire       drivers_hold;
	wire [6:0] div_factor;
	wire [7:0] reso_avg;
	wire       reso_valid;
	wire       start_found;
	reg  [7:0] rx;
	reg        ok;
	integer    fail_count = 0;
	integer    cmp_count = 0;
	integer    k;
	// ==========================================================
	// Clock, design and partner; eight periods a bit keep the data reads short
	initial forever #12.5 clk_sys = ~clk_sys;
	fse_top #(.PPB(8), .CYC_DIAG(20'h01770), .CYC_HOLD(20'h000C8), .CYC_READ(20'h0A000)) dut (
		.clk_sys(clk_sys), .nrst(nrst), .limiter_in(limiter_in), .diag_in(diag_in),
		.short_fault(short_fault), .charge_phase(charge_phase), .read_phase(read_phase),
		.write_mode(write_mode), .sync_mode(sync_mode), .div_sel(div_sel),
		.host_control_line(host_control_line), .serial_reply_output(serial_reply_output),
		.carrier_out(), .drivers_hold(drivers_hold), .div_factor(div_factor),
		.reso_avg(reso_avg), .reso_valid(reso_valid), .start_found(start_found));
	fse_host_model host (.clk_sys(clk_sys), .serial_reply_output(serial_reply_output),
		.lim_per(lim_per), .limiter_in(limiter_in), .host_control_line(host_control_line));
	// ==========================================================
	// Shared helpers
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_sys);
			#1;
		end
	endtask
	task check(input string name, input [7:0] exp, input [7:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected %s: expected %h, seen %h", name, exp, got);
			end
		end
	endtask
	task do_reset;
		begin
			nrst = 1'b0;
			tick(10);
			nrst = 1'b1;
		end
	endtask
	task finish_test;
		begin
			if (fail_count == 0 && cmp_count > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_divider;
		begin
			check("reset divider", 8'h77, {1'b0, div_factor});
			for (k = 1; k < 12; k = k + 1) begin
				div_sel = k[3:0];
				tick(2);
				check("divider", 8'h71 + k[7:0], {1'b0, div_factor});
			end
			div_sel = 4'h0;
			tick(2);
			check("default divider", 8'h77, {1'b0, div_factor});
		end
	endtask
	// Shorted bridge reported with the failure byte in an async frame
	task t_diag_async;
		begin
			lim_per = 10'h12C;
			diag_in = 1'b1;
			short_fault = 1'b1;
			charge_phase = 1'b1;
			host.async_read(rx, ok);
			check("async framing", 8'h01, {7'h00, ok});
			check("fault byte", 8'hFF, rx);
			charge_phase = 1'b0;
			short_fault = 1'b0;
			diag_in = 1'b0;
		end
	endtask
	// Good antenna in sync mode: hold drivers, clock the byte out LSB first
	task t_diag_sync;
		begin
			do_reset;
			sync_mode = 1'b1;
			diag_in = 1'b1;
			charge_phase = 1'b1;
			for (k = 0; k < 5000 && drivers_hold !== 1'b1; k = k + 1) tick(1);
			check("drivers hold", 8'h01, {7'h00, drivers_hold});
			host.sync_read(rx, ok);
			check("sync ready", 8'h01, {7'h00, ok});
			check("good byte", 8'hAF, rx);
			charge_phase = 1'b0;
			diag_in = 1'b0;
			sync_mode = 1'b0;
		end
	endtask
	// Read: resonance first, then start bit on 8 short and 4 long periods
	task t_read;
		begin
			do_reset;
			read_phase = 1'b1;
			for (k = 0; k < 9000 && reso_valid !== 1'b1; k = k + 1) tick(1);
			check("resonance avg", 8'h78, reso_avg);
			check("early start", 8'h00, {7'h00, start_found});
			div_sel = 4'hF;
			tick(2);
			check("auto divider", 8'h78, {1'b0, div_factor});
			lim_per = 10'h154;
			for (k = 0; k < 4000 && start_found !== 1'b1; k = k + 1) tick(1);
			check("start found", 8'h01, {7'h00, start_found});
			fork
				host.end_read;
				begin
					tick(5);
					check("stopped", 8'h00, {7'h00, start_found});
					check("reply idle", 8'h00, {7'h00, serial_reply_output});
				end
			join
			read_phase = 1'b0;
			div_sel = 4'h0;
		end
	endtask
	// Sync read: start bit then seven low bits, 0x01 sent, 0xFE seen inverted
	task t_read_sync;
		begin
			do_reset;
			sync_mode = 1'b1;
			lim_per = 10'h12C;
			read_phase = 1'b1;
			for (k = 0; k < 9000 && reso_valid !== 1'b1; k = k + 1) tick(1);
			lim_per = 10'h154;
			for (k = 0; k < 4000 && start_found !== 1'b1; k = k + 1) tick(1);
			lim_per = 10'h12C;
			host.sync_read(rx, ok);
			check("sync data ready", 8'h01, {7'h00, ok});
			check("start byte", 8'hFE, rx);
			host.end_read;
			check("sync stop", 8'h00, {7'h00, start_found});
			read_phase = 1'b0;
			sync_mode = 1'b0;
		end
	endtask
	// Write mode: measurement waits the fixed delay after the host line falls
	task t_write;
		begin
			do_reset;
			write_mode = 1'b1;
			fork
				host.end_read;
				begin
					tick(3000);
					check("write delay", 8'h00, {7'h00, reso_valid});
				end
			join
			for (k = 0; k < 3000 && reso_valid !== 1'b1; k = k + 1) tick(1);
			check("write measure", 8'h78, reso_avg);
			write_mode = 1'b0;
		end
	endtask
	// Main sequence and watchdog
	initial begin
		do_reset;
		t_divider;
		t_diag_async;
		t_diag_sync;
		t_read;
		t_read_sync;
		t_write;
		finish_test;
	end
	initial begin
		#2600000;
		fail_count = fail_count + 1;
		finish_test;
	end
endmodule
